// >>> hw/jsa_tap_top.v
// test access port with pin scan chain and analog probe routing
//
// Operation
// - three-bit instruction register, lsb shifted first
// - code 000 drives pins from chain
// - code 010 selects analog route register
// - code 100 samples pins, normal paths kept
// - code 110 shifts identity out
// - code 111 passes through bypass bit
// - bypass is one single stage
// - identity fields: revision, part, maker, one
// - identity shifts out lsb first
// - five-bit analog route register selects pins
// - analog instruction: tdi in, tdo out
// - five rising edges load analog code
// - codes 11111/11110 probe transmit pairs
// - codes 10111..10100 probe receive pairs
// - channel 0 control cell floats receive outputs
// - loop control cell: drive or float
// - channel 1 control cell floats receive outputs
`timescale 1ns/10ps
`include "jsa_defines.vh"
module jsa_tap_top #(
   parameter [`JSA_ID_REV_W-1:0]  ID_REVISION = 4'h1,   // arbitrary
   parameter [`JSA_ID_PART_W-1:0] ID_PART     = 16'hA5C3, // arbitrary
   parameter [`JSA_ID_MFR_W-1:0]  ID_MAKER    = 11'h2B4 // arbitrary
) (
   input  wire       i_mclk,
   input  wire       i_arst_n,
   input  wire       i_tck,
   input  wire       i_tms,
   input  wire       i_tdi,
   output reg        o_tdo,
   output reg        o_tdo_oe,
   input  wire       i_tx_clk_in_ch0,
   input  wire       i_tx_pos_data_ch0,
   input  wire       i_tx_neg_data_ch0,
   input  wire       i_core_rx_clk_ch0,
   input  wire       i_core_rx_pos_ch0,
   input  wire       i_core_rx_neg_ch0,
   input  wire       i_core_los_ch0,
   input  wire       i_core_rx_clk_ch1,
   input  wire       i_core_rx_pos_ch1,
   input  wire       i_core_rx_neg_ch1,
   input  wire       i_core_los_ch1,
   input  wire [7:0] i_core_loop_out,
   input  wire       i_core_loop_oe,
   input  wire [7:0] i_loop_pin_in,
   output reg        o_rx_recovered_clk_ch0,
   output reg        o_rx_pos_data_ch0,
   output reg        o_rx_neg_data_ch0,
   output reg        o_rx_oe_ch0,
   output reg        o_signal_lost_ch0,
   output reg        o_rx_recovered_clk_ch1,
   output reg        o_rx_pos_data_ch1,
   output reg        o_rx_neg_data_ch1,
   output reg        o_rx_oe_ch1,
   output reg        o_signal_lost_ch1,
   output reg  [7:0] o_loop_pin_out,
   output reg        o_loop_pin_oe,
   output reg        o_analog_probe_en,
   output reg  [5:0] o_analog_route
);
   localparam [15:0] S_RESET   = 16'h0001;
   localparam [15:0] S_IDLE    = 16'h0002;
   localparam [15:0] S_SEL_DR  = 16'h0004;
   localparam [15:0] S_CAP_DR  = 16'h0008;
   localparam [15:0] S_SH_DR   = 16'h0010;
   localparam [15:0] S_EX1_DR  = 16'h0020;
   localparam [15:0] S_PA_DR   = 16'h0040;
   localparam [15:0] S_EX2_DR  = 16'h0080;
   localparam [15:0] S_UPD_DR  = 16'h0100;
   localparam [15:0] S_SEL_IR  = 16'h0200;
   localparam [15:0] S_CAP_IR  = 16'h0400;
   localparam [15:0] S_SH_IR   = 16'h0800;
   localparam [15:0] S_EX1_IR  = 16'h1000;
   localparam [15:0] S_PA_IR   = 16'h2000;
   localparam [15:0] S_EX2_IR  = 16'h4000;
   localparam [15:0] S_UPD_IR  = 16'h8000;
   localparam [`JSA_ID_W-1:0] ID_WORD = {ID_REVISION, ID_PART, ID_MAKER, `JSA_ID_MARK};
   reg  [`JSA_SYNC_W-1:0] pin_s1;
   reg  [`JSA_SYNC_W-1:0] pin_s2;
   reg                    tck_s3;
   reg  [15:0]            state;
   reg  [15:0]            next_state;
   reg  [`JSA_IR_W-1:0]   ir_active;
   reg  [`JSA_BSR_W-1:0]  bsr_upd;
   reg                    dr_out;
   wire                   tck_rise;
   wire                   tck_fall;
   wire                   tms_s;
   wire                   tdi_s;
   wire [2:0]             tx_pins;
   wire [7:0]             loop_pins;
   wire [1:0]             dr_sel;
   wire                   in_reset;
   wire                   cap_dr;
   wire                   sh_dr;
   wire                   extest;
   wire [`JSA_IR_W-1:0]   ir_sh;
   wire [`JSA_BSR_W-1:0]  bsr_sh;
   wire [`JSA_BSR_W-1:0]  bsr_cap;
   wire [`JSA_ASR_W-1:0]  asr_sh;
   wire [`JSA_ID_W-1:0]   id_sh;
   wire [0:0]             byp_sh;

   // data register chosen by an instruction
   function [1:0] dr_of;
      input [`JSA_IR_W-1:0] op;
      begin
         case (op)
            `JSA_OP_EXTEST: dr_of = `JSA_DR_BSR;
            `JSA_OP_SAMPLE: dr_of = `JSA_DR_BSR;
            `JSA_OP_ANALOG: dr_of = `JSA_DR_ASR;
            `JSA_OP_IDCODE: dr_of = `JSA_DR_ID;
            default:        dr_of = `JSA_DR_BYP;
         endcase
      end
   endfunction

   // pins from outside pass two flip-flops; tck keeps a third for edges
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         pin_s1 <= {`JSA_SYNC_W{1'b0}};
         pin_s2 <= {`JSA_SYNC_W{1'b0}};
         tck_s3 <= 1'b0;
      end
      else
      begin
         pin_s1 <= {i_loop_pin_in, i_tx_neg_data_ch0, i_tx_pos_data_ch0,
                    i_tx_clk_in_ch0, i_tdi, i_tms, i_tck};
         pin_s2 <= pin_s1;
         tck_s3 <= pin_s2[0];
      end
   end

   assign tck_rise  = pin_s2[0] & ~tck_s3;
   assign tck_fall  = ~pin_s2[0] & tck_s3;
   assign tms_s     = pin_s2[1];
   assign tdi_s     = pin_s2[2];
   assign tx_pins   = pin_s2[5:3];
   assign loop_pins = pin_s2[13:6];

   // controller walk on tms at tck rising edges
   always @*
   begin
      next_state = S_RESET;
      case (state)
         S_RESET:  next_state = tms_s ? S_RESET : S_IDLE;
         S_IDLE:   next_state = tms_s ? S_SEL_DR : S_IDLE;
         S_SEL_DR: next_state = tms_s ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: next_state = tms_s ? S_EX1_DR : S_SH_DR;
         S_SH_DR:  next_state = tms_s ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: next_state = tms_s ? S_UPD_DR : S_PA_DR;
         S_PA_DR:  next_state = tms_s ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: next_state = tms_s ? S_UPD_DR : S_SH_DR;
         S_UPD_DR: next_state = tms_s ? S_SEL_DR : S_IDLE;
         S_SEL_IR: next_state = tms_s ? S_RESET : S_CAP_IR;
         S_CAP_IR: next_state = tms_s ? S_EX1_IR : S_SH_IR;
         S_SH_IR:  next_state = tms_s ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: next_state = tms_s ? S_UPD_IR : S_PA_IR;
         S_PA_IR:  next_state = tms_s ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: next_state = tms_s ? S_UPD_IR : S_SH_IR;
         S_UPD_IR: next_state = tms_s ? S_SEL_DR : S_IDLE;
         default:  next_state = S_RESET;
      endcase
   end

   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state <= S_RESET;
      end
      else if (tck_rise)
      begin
         state <= next_state;
      end
   end

   assign in_reset = (state == S_RESET);
   assign dr_sel   = dr_of(ir_active);
   assign cap_dr   = (state == S_CAP_DR);
   assign sh_dr    = (state == S_SH_DR);
   assign extest   = (ir_active == `JSA_OP_EXTEST);
   // instruction path
   jsa_shift_stage #(.WIDTH (`JSA_IR_W)) u_ir (
      .i_mclk     (i_mclk),
      .i_arst_n   (i_arst_n),
      .i_step     (tck_rise),
      .i_clear    (1'b0),
      .i_capture  (state == S_CAP_IR),
      .i_shift    (state == S_SH_IR),
      .i_tdi      (tdi_s),
      .i_cap_data (`JSA_IR_CAPTURE),
      .o_data     (ir_sh)
   );

   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ir_active <= `JSA_OP_IDCODE;
      end
      else if (tck_rise)
      begin
         if (in_reset)
         begin
            ir_active <= `JSA_OP_IDCODE;
         end
         else if (state == S_UPD_IR)
         begin
            ir_active <= ir_sh;
         end
      end
   end

   // pin chain capture: transmit inputs from pins, outputs from the core
   assign bsr_cap = {~i_core_loop_oe, i_core_loop_out, loop_pins,
                     bsr_upd[`JSA_BIT_RX_FLOAT_CTRL_CH1], i_core_los_ch1, i_core_rx_neg_ch1,
                     i_core_rx_pos_ch1, i_core_rx_clk_ch1, bsr_upd[`JSA_BIT_RX_FLOAT_CTRL_CH0],
                     i_core_los_ch0, i_core_rx_neg_ch0, i_core_rx_pos_ch0, i_core_rx_clk_ch0,
                     tx_pins};
   jsa_shift_stage #(.WIDTH (`JSA_BSR_W)) u_bsr (
      .i_mclk     (i_mclk),
      .i_arst_n   (i_arst_n),
      .i_step     (tck_rise),
      .i_clear    (1'b0),
      .i_capture  (cap_dr && dr_sel == `JSA_DR_BSR),
      .i_shift    (sh_dr && dr_sel == `JSA_DR_BSR),
      .i_tdi      (tdi_s),
      .i_cap_data (bsr_cap),
      .o_data     (bsr_sh)
   );

   // update latch; preload under sample, drive under extest
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         bsr_upd <= {`JSA_BSR_W{1'b0}};
      end
      else if (tck_rise && state == S_UPD_DR && dr_sel == `JSA_DR_BSR)
      begin
         bsr_upd <= bsr_sh;
      end
   end

   // analog route register holds its code; cleared on controller reset
   jsa_shift_stage #(.WIDTH (`JSA_ASR_W)) u_asr (
      .i_mclk     (i_mclk),
      .i_arst_n   (i_arst_n),
      .i_step     (tck_rise),
      .i_clear    (in_reset),
      .i_capture  (1'b0),
      .i_shift    (sh_dr && dr_sel == `JSA_DR_ASR),
      .i_tdi      (tdi_s),
      .i_cap_data (asr_sh),
      .o_data     (asr_sh)
   );
   jsa_shift_stage #(.WIDTH (`JSA_ID_W)) u_id (
      .i_mclk     (i_mclk),
      .i_arst_n   (i_arst_n),
      .i_step     (tck_rise),
      .i_clear    (1'b0),
      .i_capture  (cap_dr && dr_sel == `JSA_DR_ID),
      .i_shift    (sh_dr && dr_sel == `JSA_DR_ID),
      .i_tdi      (tdi_s),
      .i_cap_data (ID_WORD),
      .o_data     (id_sh)
   );
   jsa_shift_stage #(.WIDTH (1)) u_byp (
      .i_mclk     (i_mclk),
      .i_arst_n   (i_arst_n),
      .i_step     (tck_rise),
      .i_clear    (1'b0),
      .i_capture  (cap_dr && dr_sel == `JSA_DR_BYP),
      .i_shift    (sh_dr && dr_sel == `JSA_DR_BYP),
      .i_tdi      (tdi_s),
      .i_cap_data (1'b0),
      .o_data     (byp_sh)
   );

   always @*
   begin
      case (dr_sel)
         `JSA_DR_BSR: dr_out = bsr_sh[0];
         `JSA_DR_ASR: dr_out = asr_sh[0];
         `JSA_DR_ID:  dr_out = id_sh[0];
         default:     dr_out = byp_sh[0];
      endcase
   end

   // tdo changes on the tck falling edge, driven only while shifting
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         o_tdo    <= (state == S_SH_IR) ? ir_sh[0] : dr_out;
         o_tdo_oe <= (state == S_SH_IR) || sh_dr;
      end
   end

   // pin drivers: core paths unless the chain owns the pins
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         {o_rx_recovered_clk_ch0, o_rx_pos_data_ch0, o_rx_neg_data_ch0, o_rx_oe_ch0,
          o_signal_lost_ch0, o_rx_recovered_clk_ch1, o_rx_pos_data_ch1, o_rx_neg_data_ch1,
          o_rx_oe_ch1, o_signal_lost_ch1, o_loop_pin_out, o_loop_pin_oe} <= 19'h00000;
      end
      else
      begin
         o_rx_recovered_clk_ch0 <= extest ? bsr_upd[`JSA_BIT_RX_RECOVERED_CLK_CH0] : i_core_rx_clk_ch0;
         o_rx_pos_data_ch0      <= extest ? bsr_upd[`JSA_BIT_RX_POS_DATA_CH0] : i_core_rx_pos_ch0;
         o_rx_neg_data_ch0      <= extest ? bsr_upd[`JSA_BIT_RX_NEG_DATA_CH0] : i_core_rx_neg_ch0;
         o_rx_oe_ch0            <= ~(extest & bsr_upd[`JSA_BIT_RX_FLOAT_CTRL_CH0]);
         o_signal_lost_ch0      <= extest ? bsr_upd[`JSA_BIT_SIGNAL_LOST_CH0] : i_core_los_ch0;
         o_rx_recovered_clk_ch1 <= extest ? bsr_upd[`JSA_BIT_RCLK1] : i_core_rx_clk_ch1;
         o_rx_pos_data_ch1      <= extest ? bsr_upd[`JSA_BIT_RPOS1] : i_core_rx_pos_ch1;
         o_rx_neg_data_ch1      <= extest ? bsr_upd[`JSA_BIT_RX_NEG_DATA_CH1] : i_core_rx_neg_ch1;
         o_rx_oe_ch1            <= ~(extest & bsr_upd[`JSA_BIT_RX_FLOAT_CTRL_CH1]);
         o_signal_lost_ch1      <= extest ? bsr_upd[`JSA_BIT_SIGNAL_LOST_CH1] : i_core_los_ch1;
         o_loop_pin_out         <= extest ? bsr_upd[`JSA_BIT_LPOUT +: 8] : i_core_loop_out;
         o_loop_pin_oe          <= extest ? ~bsr_upd[`JSA_BIT_LPCTL] : i_core_loop_oe;
      end
   end
   // analog probe routing, one-hot: tx0, tx1, rx0, rx1, rx2, rx3
   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_analog_route    <= 6'h00;
         o_analog_probe_en <= 1'b0;
      end
      else if (ir_active == `JSA_OP_ANALOG)
      begin
         o_analog_probe_en <= 1'b1;
         case (asr_sh)
            `JSA_AC_TX0: o_analog_route <= 6'h01;
            `JSA_AC_TX1: o_analog_route <= 6'h02;
            `JSA_AC_RX0: o_analog_route <= 6'h04;
            `JSA_AC_RX1: o_analog_route <= 6'h08;
            `JSA_AC_RX2: o_analog_route <= 6'h10;
            `JSA_AC_RX3: o_analog_route <= 6'h20;
            default:     o_analog_route <= 6'h00;
         endcase
      end
      else
      begin
         o_analog_route    <= 6'h00;
         o_analog_probe_en <= 1'b0;
      end
   end
endmodule // jsa_tap_top

// >>> hw/jsa_defines.vh
// constants for the boundary-scan and analog probe access logic
`ifndef JSA_DEFINES_VH
`define JSA_DEFINES_VH
`define JSA_IR_W 3
`define JSA_ASR_W 5
`define JSA_ID_W 32
`define JSA_BSR_W 30
`define JSA_ROUTE_W 6
`define JSA_SYNC_W 14
`define JSA_OP_EXTEST 3'h0
`define JSA_OP_ANALOG 3'h2
`define JSA_OP_SAMPLE 3'h4
`define JSA_OP_IDCODE 3'h6
`define JSA_OP_BYPASS 3'h7
`define JSA_IR_CAPTURE 3'h1
`define JSA_DR_BSR 2'h0
`define JSA_DR_ASR 2'h1
`define JSA_DR_ID 2'h2
`define JSA_DR_BYP 2'h3
`define JSA_ID_REV_W 4
`define JSA_ID_PART_W 16
`define JSA_ID_MFR_W 11
`define JSA_ID_MARK 1'h1
`define JSA_AC_TX0 5'h1F
`define JSA_AC_TX1 5'h1E
`define JSA_AC_RX0 5'h17
`define JSA_AC_RX1 5'h16
`define JSA_AC_RX2 5'h15
`define JSA_AC_RX3 5'h14
`define JSA_BIT_TXCLK0 0
`define JSA_BIT_TXPOS0 1
`define JSA_BIT_TXNEG0 2
`define JSA_BIT_RX_RECOVERED_CLK_CH0 3
`define JSA_BIT_RX_POS_DATA_CH0 4
`define JSA_BIT_RX_NEG_DATA_CH0 5
`define JSA_BIT_SIGNAL_LOST_CH0 6
`define JSA_BIT_RX_FLOAT_CTRL_CH0 7
`define JSA_BIT_RCLK1 8
`define JSA_BIT_RPOS1 9
`define JSA_BIT_RX_NEG_DATA_CH1 10
`define JSA_BIT_SIGNAL_LOST_CH1 11
`define JSA_BIT_RX_FLOAT_CTRL_CH1 12
`define JSA_BIT_LPIN 13
`define JSA_BIT_LPOUT 21
`define JSA_BIT_LPCTL 29
`endif

// >>> hw/jsa_shift_stage.v
// one capture and shift stage of the scan paths, lsb out first
`timescale 1ns/10ps
module jsa_shift_stage #(
   parameter WIDTH = 1
) (
   input  wire             i_mclk,
   input  wire             i_arst_n,
   input  wire             i_step,
   input  wire             i_clear,
   input  wire             i_capture,
   input  wire             i_shift,
   input  wire             i_tdi,
   input  wire [WIDTH-1:0] i_cap_data,
   output reg  [WIDTH-1:0] o_data
);
   wire [WIDTH:0] cat;

   assign cat = {i_tdi, o_data};

   always @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_data <= {WIDTH{1'b0}};
      end
      else if (i_step)
      begin
         if (i_clear)
         begin
            o_data <= {WIDTH{1'b0}};
         end
         else if (i_capture)
         begin
            o_data <= i_cap_data;
         end
         else if (i_shift)
         begin
            // new bit enters at the top, so the first bit in ends at bit 0
            o_data <= cat[WIDTH:1];
         end
      end
   end
endmodule // jsa_shift_stage

// >>> hw/placeholder_end.v
// intentionally empty marker of end of design set
`timescale 1ns/10ps

// >>> testbench/jsa_tap_asserts.sv
// assertions on the test access port outputs
`timescale 1ns/10ps
module jsa_tap_asserts (
   input wire logic       i_mclk,
   input wire logic       i_arst_n,
   input wire logic       i_tck,
   input wire logic       o_tdo,
   input wire logic       o_tdo_oe,
   input wire logic       o_rx_oe_ch0,
   input wire logic       o_rx_oe_ch1,
   input wire logic       o_analog_probe_en,
   input wire logic [5:0] o_analog_route
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_arst_n);

   a_tdo_at_fall: assert property ($changed(o_tdo) |-> !$past(i_tck) && !$past(i_tck, 2))
      else $error("serial out moved while test clock high");
   a_tdo_oe_fall: assert property ($changed(o_tdo_oe) |-> !$past(i_tck) && !$past(i_tck, 2))
      else $error("serial enable moved while test clock high");
   a_route_onehot: assert property ($onehot0(o_analog_route))
      else $error("analog route not one-hot");
   a_route_idle: assert property (!o_analog_probe_en && !$past(o_analog_probe_en) |-> o_analog_route == 6'h00)
      else $error("analog route set without probe instruction");
   a_probe_at_rise: assert property ($changed(o_analog_probe_en) |-> $past(i_tck) && $past(i_tck, 2))
      else $error("probe enable moved off a test clock rise");
   a_route_at_rise: assert property ($changed(o_analog_route) |-> $past(i_tck) && $past(i_tck, 2))
      else $error("analog route moved off a test clock rise");
   a_float_extest: assert property (!o_rx_oe_ch0 || !o_rx_oe_ch1 |-> !o_analog_probe_en)
      else $error("receive outputs floated under probe instruction");
   a_rxoe_at_rise: assert property ($past(i_arst_n, 2) && $changed({o_rx_oe_ch0, o_rx_oe_ch1}) |-> $past(i_tck) && $past(i_tck, 2))
      else $error("receive enable moved off a test clock rise");

   c_probe_on: cover property ($rose(o_analog_probe_en));
   c_ch0_float: cover property ($fell(o_rx_oe_ch0));
   c_rx3_route: cover property (o_analog_route == 6'h20);
endmodule // jsa_tap_asserts

bind jsa_tap_top jsa_tap_asserts jsa_tap_asserts_inst (
   .i_mclk            (i_mclk),
   .i_arst_n          (i_arst_n),
   .i_tck             (i_tck),
   .o_tdo             (o_tdo),
   .o_tdo_oe          (o_tdo_oe),
   .o_rx_oe_ch0       (o_rx_oe_ch0),
   .o_rx_oe_ch1       (o_rx_oe_ch1),
   .o_analog_probe_en (o_analog_probe_en),
   .o_analog_route    (o_analog_route)
);

// >>> testbench/jsa_tap_master.sv
// test controller model driving the scan port pins
`timescale 1ns/10ps
module jsa_tap_master (
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo
);
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end

   // one 80 ns period; tdo taken while clock high
   task automatic step(input logic tms, input logic tdi, output logic tdo);
   begin
      o_tck = 1'b0;
      o_tms = tms;
      o_tdi = tdi;
      #40;
      o_tck = 1'b1;
      #20;
      tdo = i_tdo;
      #20;
   end
   endtask

   // clock stands low, data line pulled up between frames
   task automatic park;
   begin
      o_tck = 1'b0;
      o_tdi = 1'b1;
   end
   endtask

   task automatic reset_tap;
      logic t;
   begin
      #3;
      repeat (5) step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
      park;
   end
   endtask

   // from idle through capture, n shifts lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic t;
   begin
      #3;
      dout = 32'h0;
      step(1'b1, 1'b1, t);
      if (ir)
         step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
      step(1'b0, 1'b1, t);
      for (int i = 0; i < n; i++)
         step(i == n - 1, din[i], dout[i]);
      step(1'b1, 1'b1, t);
      step(1'b0, 1'b1, t);
      park;
   end
   endtask
endmodule // jsa_tap_master

// >>> testbench/test_jtag_scan_with_analog_port.sv
// self-checking bench for the scan port with analog probe routing
`timescale 1ns/10ps
`include "jsa_defines.vh"
module test_jtag_scan_with_analog_port;
   localparam logic [3:0]  REV  = 4'h3;     // arbitrary
   localparam logic [15:0] PART = 16'h5E71; // arbitrary
   localparam logic [10:0] MAKR = 11'h0D2;  // arbitrary
   localparam logic [31:0] MASK = 32'h3FE0_1FF8;
   localparam logic [2:0]  BYP_OP [0:3] = '{3'h7, 3'h1, 3'h3, 3'h5};
   localparam logic [4:0]  ACODE [0:6] = '{5'h1F, 5'h1E, 5'h17, 5'h16, 5'h15, 5'h14, 5'h1B};
   localparam logic [5:0]  AROUTE [0:6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00};
   logic       i_mclk, i_arst_n, tck, tms, tdi, tdo, tdo_oe, loop_oe, loop_pin_oe;
   logic       probe_en, rx_oe0, rx_oe1;
   logic [2:0] tx_in;
   logic [3:0] core0, core1;
   wire  [3:0] rx0, rx1;
   logic [7:0] loop_out, loop_in, loop_pin_out;
   logic [5:0] route;
   int         err_total, check_count;
   wire        tdo_pin = tdo_oe ? tdo : 1'b1;

   always #5 i_mclk = ~i_mclk;

   jsa_tap_top #(
      .ID_REVISION (REV),
      .ID_PART     (PART),
      .ID_MAKER    (MAKR)
   ) jsa_tap_top_inst (
      .i_mclk                 (i_mclk),
      .i_arst_n               (i_arst_n),
      .i_tck                  (tck),
      .i_tms                  (tms),
      .i_tdi                  (tdi),
      .o_tdo                  (tdo),
      .o_tdo_oe               (tdo_oe),
      .i_tx_clk_in_ch0        (tx_in[0]),
      .i_tx_pos_data_ch0      (tx_in[1]),
      .i_tx_neg_data_ch0      (tx_in[2]),
      .i_core_rx_clk_ch0      (core0[0]),
      .i_core_rx_pos_ch0      (core0[1]),
      .i_core_rx_neg_ch0      (core0[2]),
      .i_core_los_ch0         (core0[3]),
      .i_core_rx_clk_ch1      (core1[0]),
      .i_core_rx_pos_ch1      (core1[1]),
      .i_core_rx_neg_ch1      (core1[2]),
      .i_core_los_ch1         (core1[3]),
      .i_core_loop_out        (loop_out),
      .i_core_loop_oe         (loop_oe),
      .i_loop_pin_in          (loop_in),
      .o_rx_recovered_clk_ch0 (rx0[0]),
      .o_rx_pos_data_ch0      (rx0[1]),
      .o_rx_neg_data_ch0      (rx0[2]),
      .o_rx_oe_ch0            (rx_oe0),
      .o_signal_lost_ch0      (rx0[3]),
      .o_rx_recovered_clk_ch1 (rx1[0]),
      .o_rx_pos_data_ch1      (rx1[1]),
      .o_rx_neg_data_ch1      (rx1[2]),
      .o_rx_oe_ch1            (rx_oe1),
      .o_signal_lost_ch1      (rx1[3]),
      .o_loop_pin_out         (loop_pin_out),
      .o_loop_pin_oe          (loop_pin_oe),
      .o_analog_probe_en      (probe_en),
      .o_analog_route         (route)
   );

   jsa_tap_master jsa_tap_master_inst (
      .o_tck (tck),
      .o_tms (tms),
      .o_tdi (tdi),
      .i_tdo (tdo_pin)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task automatic conclude;
   begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask

   function automatic logic [31:0] cap(input logic c0, input logic c1);
      return {2'b00, ~loop_oe, loop_out, loop_in, c1, core1, c0, core0, tx_in};
   endfunction

   function automatic logic [31:0] pins;
      return {2'b00, ~loop_pin_oe, loop_pin_out, 8'h00, ~rx_oe1, rx1, ~rx_oe0, rx0, 3'h0};
   endfunction

   task automatic settle;
   begin
      repeat (4) @(posedge i_mclk);
      #1;
   end
   endtask

   task automatic load_ir(input logic [2:0] op);
      logic [31:0] q;
   begin
      @(posedge i_mclk);
      jsa_tap_master_inst.scan(1'b1, 3, {29'h0, op}, q);
      chk(q, 32'h1);
   end
   endtask

   task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] q);
   begin
      @(posedge i_mclk);
      jsa_tap_master_inst.scan(1'b0, n, din, q);
   end
   endtask

   task automatic test_idcode;
      logic [31:0] q;
   begin
      @(posedge i_mclk);
      jsa_tap_master_inst.reset_tap;
      shift_dr(32, 32'h0, q);
      chk(q, {REV, PART, MAKR, 1'b1});
      $display("test_idcode done");
   end
   endtask

   task automatic test_bypass;
      logic [31:0] q;
   begin
      for (int i = 0; i < 4; i++)
      begin
         load_ir(BYP_OP[i]);
         shift_dr(8, 32'hA5, q);
         chk(q, 32'h4A);
      end
      $display("test_bypass done");
   end
   endtask

   task automatic test_analog;
      logic [31:0] q;
      logic [4:0]  prev;
   begin
      @(posedge i_mclk);
      jsa_tap_master_inst.reset_tap;
      load_ir(`JSA_OP_ANALOG);
      settle;
      chk({25'h0, probe_en, route}, 32'h40);
      prev = 5'h00;
      for (int i = 0; i < 7; i++)
      begin
         shift_dr(5, {27'h0, ACODE[i]}, q);
         chk(q, {27'h0, prev});
         settle;
         chk({25'h0, probe_en, route}, {25'h0, 1'b1, AROUTE[i]});
         prev = ACODE[i];
      end
      load_ir(`JSA_OP_BYPASS);
      settle;
      chk({25'h0, probe_en, route}, 32'h0);
      $display("test_analog done");
   end
   endtask

   task automatic test_scan;
      logic [31:0] q;
   begin
      @(posedge i_mclk);
      tx_in <= 3'b101;
      core0 <= 4'b1011;
      core1 <= 4'b0110;
      loop_out <= 8'h3C;
      loop_oe <= 1'b1;
      loop_in <= 8'hA6;
      load_ir(`JSA_OP_SAMPLE);
      shift_dr(30, 32'h12C0_1550, q);
      chk(q, cap(1'b0, 1'b0));
      settle;
      chk(pins(), cap(1'b0, 1'b0) & MASK);
      load_ir(`JSA_OP_EXTEST);
      settle;
      chk(pins(), 32'h12C0_1550 & MASK);
      shift_dr(30, 32'h2780_0AA8, q);
      chk(q, cap(1'b0, 1'b1));
      settle;
      chk(pins(), 32'h2780_0AA8 & MASK);
      $display("test_scan done");
   end
   endtask

   initial
   begin
      i_mclk = 1'b0;
      i_arst_n = 1'b0;
      {tx_in, core0, core1, loop_out, loop_oe, loop_in} = 28'h0;
      repeat (6) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      repeat (4) @(posedge i_mclk);
      test_idcode;
      test_bypass;
      test_analog;
      test_scan;
      test_idcode;
      conclude;
   end

   initial
   begin
      repeat (100000) @(posedge i_mclk);
      err_total++;
      conclude;
   end
endmodule // test_jtag_scan_with_analog_port
